// [bpp_seq_top.sv]
/*
 * Command sequencer for program-through-buffer, byte program and
 * read-modify-write. Receives bytes from the link, fills two page buffers,
 * then drives a byte-wide array port after chip select rises.
 * Assumes the array answers each request with one arrayDone pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module bpp_seq_top #(
    parameter int unsigned EP_LIMIT_NS = 40_000_000,
    parameter int unsigned P_LIMIT_NS  = 5_000_000
) (
    // system
    input  wire logic              mclk,
    input  wire logic              nrst,
    // serial link
    input  wire logic              sck,
    input  wire logic              csN,
    input  wire logic              si,
    // configuration
    input  wire logic              binaryMode,
    // status
    output logic                   deviceReady,
    output logic                   eraseProgramErrorFlag,
    // array port
    output logic                   arrayReq,
    output bpp_pkg::bpp_cmd_t      arrayCmd,
    output logic [11:0]            arrayPage,
    output logic [8:0]             arrayCol,
    output logic [7:0]             arrayWdata,
    input  wire logic [7:0]        arrayRdata,
    input  wire logic              arrayDone,
    input  wire logic              arrayFail
);
    localparam logic [31:0] EP_CYC = 32'(EP_LIMIT_NS / bpp_pkg::CLK_PERIOD_NS);
    localparam logic [31:0] P_CYC  = 32'(P_LIMIT_NS / bpp_pkg::CLK_PERIOD_NS);

    bpp_link_if lnk ();

    bpp_link_rx uRx (
        .nrst (nrst),
        .sck  (sck),
        .csN  (csN),
        .si   (si),
        .lnk  (lnk.rx)
    );

    logic csS;
    logic partialS;
    logic tglS;

    bpp_sync #(.W(3), .RST_VAL(bpp_pkg::SYNC_RST)) uSync (
        .clk  (mclk),
        .nrst (nrst),
        .d    ({csN, lnk.partial, lnk.byteTgl}),
        .q    ({csS, partialS, tglS})
    );

    logic                  csS_q;
    logic                  tglS_q;
    logic [2:0]            hdrCnt_q;
    bpp_pkg::bpp_kind_t    kind_q;
    logic                  bufSel_q;
    logic [23:0]           addr_q;
    logic [8:0]            col_q;
    logic [8:0]            dataCnt_q;
    logic [263:0]          mask_q;
    logic                  frameOk_q;
    bpp_pkg::bpp_state_t   state_q;
    logic [8:0]            scan_q;
    logic                  pend_q;
    logic [31:0]           timer_q;
    logic                  epe_q;
    logic [11:0]           page_q;
    logic [7:0]            bufMem_q [2][bpp_pkg::BUF_DEPTH];

    logic       csFall;
    logic       csRise;
    logic       byteEv;
    logic       dataEv;
    logic       idle;
    logic       hdrDone;
    logic       needAbort;
    logic       startOp;
    logic       abortEv;
    logic       issue;
    logic       lastCol;
    logic       timeout;
    logic [8:0] psize;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            csS_q <= 1'b1;
        end else begin
            csS_q <= csS;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tglS_q <= 1'b0;
        end else begin
            tglS_q <= tglS;
        end
    end

    assign csFall    = csS_q & ~csS;
    assign csRise    = ~csS_q & csS;
    assign byteEv    = tglS ^ tglS_q;
    assign idle      = (state_q == bpp_pkg::ST_IDLE);
    assign hdrDone   = (hdrCnt_q == bpp_pkg::HDR_BYTES);
    assign dataEv    = byteEv && frameOk_q && hdrDone;
    assign psize     = bpp_pkg::pageSize(binaryMode);
    assign needAbort = partialS && (kind_q == bpp_pkg::K_BYTEPROG || kind_q == bpp_pkg::K_RMW);
    assign startOp   = csRise && frameOk_q && hdrDone && idle && !needAbort;
    assign abortEv   = csRise && frameOk_q && hdrDone && needAbort;
    assign lastCol   = (scan_q == psize - 9'h001);
    assign timeout   = !idle && (timer_q >= ((kind_q == bpp_pkg::K_ERASEPROG) ? EP_CYC : P_CYC));

    // frame capture: opcode, three address bytes, then data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hdrCnt_q  <= '0;
            kind_q    <= bpp_pkg::K_NONE;
            bufSel_q  <= 1'b0;
            addr_q    <= '0;
            col_q     <= '0;
            dataCnt_q <= '0;
            mask_q    <= '0;
            frameOk_q <= 1'b0;
        end else if (csFall && idle) begin
            hdrCnt_q  <= '0;
            dataCnt_q <= '0;
            mask_q    <= '0;
            frameOk_q <= 1'b1;
        end else if (csFall) begin
            frameOk_q <= 1'b0;
        end else if (byteEv && frameOk_q) begin
            if (hdrCnt_q == '0) begin
                kind_q    <= bpp_pkg::kindOf(lnk.byteData);
                bufSel_q  <= bpp_pkg::bufOf(lnk.byteData);
                frameOk_q <= (bpp_pkg::kindOf(lnk.byteData) != bpp_pkg::K_NONE);
                hdrCnt_q  <= hdrCnt_q + 3'h1;
            end else if (!hdrDone) begin
                addr_q   <= {addr_q[15:0], lnk.byteData};
                hdrCnt_q <= hdrCnt_q + 3'h1;
                col_q    <= bpp_pkg::colOf({addr_q[15:0], lnk.byteData}, binaryMode);
            end else begin
                mask_q[col_q] <= 1'b1;
                col_q         <= (col_q == psize - 9'h001) ? 9'h000 : col_q + 9'h001;
                if (dataCnt_q != psize) begin
                    dataCnt_q <= dataCnt_q + 9'h001;
                end
            end
        end
    end

    // buffer memory: host data, then page load for read-modify-write
    always_ff @(posedge mclk) begin
        if (dataEv) begin
            bufMem_q[bufSel_q][col_q] <= lnk.byteData;
        end else if (state_q == bpp_pkg::ST_LOAD && pend_q && arrayDone) begin
            bufMem_q[bufSel_q][scan_q] <= arrayRdata;
        end
    end

    always_comb begin
        unique case (state_q)
            bpp_pkg::ST_IDLE:  issue = 1'b0;
            bpp_pkg::ST_LOAD:  issue = !pend_q && !mask_q[scan_q];
            bpp_pkg::ST_ERASE: issue = !pend_q;
            bpp_pkg::ST_PROG:  issue = !pend_q
                && (kind_q != bpp_pkg::K_BYTEPROG || mask_q[scan_q]);
        endcase
    end

    // sequencer: load, erase, program, one array request at a time
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= bpp_pkg::ST_IDLE;
            scan_q  <= '0;
            pend_q  <= 1'b0;
            page_q  <= '0;
        end else if (startOp) begin
            page_q <= bpp_pkg::pageOf(addr_q, binaryMode);
            scan_q <= '0;
            pend_q <= 1'b0;
            unique case (kind_q)
                bpp_pkg::K_RMW:      state_q <= bpp_pkg::ST_LOAD;
                bpp_pkg::K_BYTEPROG: state_q <= bpp_pkg::ST_PROG;
                default:             state_q <= bpp_pkg::ST_ERASE;
            endcase
        end else if (timeout) begin
            state_q <= bpp_pkg::ST_IDLE;
            pend_q  <= 1'b0;
        end else if (issue) begin
            pend_q <= 1'b1;
        end else if (!idle && (arrayDone || !pend_q)) begin
            pend_q <= 1'b0;
            if (state_q == bpp_pkg::ST_ERASE) begin
                state_q <= bpp_pkg::ST_PROG;
                scan_q  <= '0;
            end else if (lastCol) begin
                scan_q  <= '0;
                state_q <= (state_q == bpp_pkg::ST_LOAD) ? bpp_pkg::ST_ERASE : bpp_pkg::ST_IDLE;
            end else begin
                scan_q <= scan_q + 9'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            timer_q <= '0;
        end else if (idle) begin
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 32'h0000_0001;
        end
    end

    // error flag: cleared by a new start, set wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            epe_q <= 1'b0;
        end else if ((pend_q && arrayDone && arrayFail) || timeout) begin
            epe_q <= 1'b1;
        end else if (startOp) begin
            epe_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            arrayReq   <= 1'b0;
            arrayCmd   <= bpp_pkg::CMD_READ;
            arrayPage  <= '0;
            arrayCol   <= '0;
            arrayWdata <= '0;
        end else begin
            arrayReq <= issue && !timeout;
            if (issue) begin
                arrayPage  <= page_q;
                arrayCol   <= scan_q;
                arrayWdata <= bufMem_q[bufSel_q][scan_q];
                unique case (state_q)
                    bpp_pkg::ST_LOAD:  arrayCmd <= bpp_pkg::CMD_READ;
                    bpp_pkg::ST_ERASE: arrayCmd <= bpp_pkg::CMD_ERASE;
                    default:           arrayCmd <= bpp_pkg::CMD_PROG;
                endcase
            end
        end
    end

    assign deviceReady           = idle;
    assign eraseProgramErrorFlag = epe_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_start_busy: assert property (startOp |=> !deviceReady [*2])
        else $error("busy not shown after start");
    chk_erase_first: assert property (startOp && kind_q == bpp_pkg::K_ERASEPROG
        |=> state_q == bpp_pkg::ST_ERASE)
        else $error("erase-program did not begin with erase");
    chk_no_erase_byte: assert property (arrayReq && kind_q == bpp_pkg::K_BYTEPROG
        |-> arrayCmd == bpp_pkg::CMD_PROG)
        else $error("byte program issued a non-program request");
    chk_prog_only_rx: assert property (arrayReq && arrayCmd == bpp_pkg::CMD_PROG
        && kind_q == bpp_pkg::K_BYTEPROG |-> mask_q[arrayCol])
        else $error("byte program wrote an unreceived byte");
    chk_abort_ragged: assert property (abortEv |=> deviceReady && !arrayReq)
        else $error("ragged frame end was not aborted");
    chk_wrap_col: assert property (dataEv && col_q == psize - 9'h001
        |=> col_q == 9'h000)
        else $error("buffer position did not wrap");
    chk_epe_set: assert property (pend_q && arrayDone && arrayFail
        |=> eraseProgramErrorFlag)
        else $error("failure did not set error flag");
    chk_load_skip: assert property (arrayReq && arrayCmd == bpp_pkg::CMD_READ
        |-> !mask_q[arrayCol])
        else $error("page load overwrote a received byte");
    chk_bin_page: assert property (startOp && binaryMode
        |=> page_q == $past(addr_q[19:8]))
        else $error("binary page bits misplaced");
    chk_rmw_decode: assert property (byteEv && frameOk_q && hdrCnt_q == 3'h0
        && lnk.byteData == bpp_pkg::OP_RMW_B2 |=> kind_q == bpp_pkg::K_RMW && bufSel_q)
        else $error("rmw opcode misdecoded");
    chk_count_cap: assert property (dataCnt_q <= psize)
        else $error("data count passed page size");
    chk_rewrite_empty: assert property (startOp && kind_q == bpp_pkg::K_RMW && dataCnt_q == '0
        |=> state_q == bpp_pkg::ST_LOAD
        ##1 (arrayReq && arrayCmd == bpp_pkg::CMD_READ && arrayCol == '0))
        else $error("empty rmw did not rewrite page");

    cov_erase_prog: cover property (startOp && kind_q == bpp_pkg::K_ERASEPROG);
    cov_byte_prog: cover property (startOp && kind_q == bpp_pkg::K_BYTEPROG);
    cov_rmw: cover property (startOp && kind_q == bpp_pkg::K_RMW && dataCnt_q != '0);
    cov_abort: cover property (abortEv);
endmodule
`default_nettype wire

// [bpp_pkg.sv]
/*
 * Shared constants, types and decode helpers for the buffered page program
 * sequencer. Assumes a 50 MHz system clock and a host that shifts bytes MSB first.
 */
`default_nettype none
package bpp_pkg;
    // opcodes
    localparam logic [7:0] OP_PROG_ERASE_B1 = 8'h82;
    localparam logic [7:0] OP_PROG_ERASE_B2 = 8'h85;
    localparam logic [7:0] OP_BYTE_PROG     = 8'h02;
    localparam logic [7:0] OP_RMW_B1        = 8'h58;
    localparam logic [7:0] OP_RMW_B2        = 8'h59;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam logic [8:0]  PAGE_STD      = 9'h108;
    localparam logic [8:0]  PAGE_BIN      = 9'h100;
    localparam int          BUF_DEPTH     = 264;
    localparam int          PAGE_W        = 12;
    localparam int          STD_PAGE_LSB  = 9;
    localparam int          BIN_PAGE_LSB  = 8;
    localparam int          BIN_COL_W     = 8;
    localparam logic [2:0]  HDR_BYTES     = 3'h4;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam logic [2:0]  SYNC_RST      = 3'h4;

    typedef enum logic [1:0] {CMD_READ = 2'h0, CMD_ERASE = 2'h1, CMD_PROG = 2'h2} bpp_cmd_t;
    typedef enum logic [1:0] {K_NONE, K_ERASEPROG, K_BYTEPROG, K_RMW} bpp_kind_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_ERASE = 2'b11,
        ST_PROG  = 2'b10
    } bpp_state_t;

    function automatic bpp_kind_t kindOf(input logic [7:0] op);
        case (op)
            OP_PROG_ERASE_B1, OP_PROG_ERASE_B2: kindOf = K_ERASEPROG;
            OP_BYTE_PROG:                       kindOf = K_BYTEPROG;
            OP_RMW_B1, OP_RMW_B2:               kindOf = K_RMW;
            default:                            kindOf = K_NONE;
        endcase
    endfunction

    function automatic logic bufOf(input logic [7:0] op);
        bufOf = (op == OP_PROG_ERASE_B2) || (op == OP_RMW_B2);
    endfunction

    function automatic logic [8:0] pageSize(input logic bin);
        pageSize = bin ? PAGE_BIN : PAGE_STD;
    endfunction

    function automatic logic [8:0] colOf(input logic [23:0] a, input logic bin);
        colOf = bin ? {1'b0, a[BIN_COL_W-1:0]} : a[STD_PAGE_LSB-1:0];
    endfunction

    function automatic logic [11:0] pageOf(input logic [23:0] a, input logic bin);
        pageOf = bin ? a[BIN_PAGE_LSB +: PAGE_W] : a[STD_PAGE_LSB +: PAGE_W];
    endfunction
endpackage
`default_nettype wire

// [bpp_link_if.sv]
/*
 * Carrier from the serial receiver (link clock) to the sequencer (mclk).
 * byteData is held stable from one byteTgl change to the next.
 */
`timescale 1ns/1ns
`default_nettype none
interface bpp_link_if;
    logic [7:0] byteData;
    logic       byteTgl;
    logic       partial;
    modport rx  (output byteData, output byteTgl, output partial);
    modport seq (input byteData, input byteTgl, input partial);
endinterface
`default_nettype wire

// [bpp_sync.sv]
/*
 * Two-flop level synchroniser with a constant reset pattern.
 * Assumes each bit is a level held for several destination clocks.
 */
`timescale 1ns/1ns
`default_nettype none
module bpp_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [bpp_link_rx.sv]
/*
 * Serial byte receiver on the link clock, mode 0: si sampled on rising sck.
 * Assumes sck idles outside frames; chip select high clears the bit count.
 */
`timescale 1ns/1ns
`default_nettype none
module bpp_link_rx (
    // reset
    input  wire logic nrst,
    // serial pins
    input  wire logic sck,
    input  wire logic csN,
    input  wire logic si,
    // to sequencer
    bpp_link_if.rx    lnk
);
    logic       linkRst;
    logic [2:0] bitCnt_q;
    logic [6:0] shift_q;
    logic [7:0] byte_q;
    logic       tgl_q;
    logic       partial_q;

    assign linkRst = csN | ~nrst;

    always_ff @(posedge sck or posedge linkRst) begin
        if (linkRst) begin
            bitCnt_q <= '0;
        end else begin
            bitCnt_q <= bitCnt_q + 3'h1;
        end
    end

    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            shift_q <= '0;
        end else begin
            shift_q <= {shift_q[5:0], si};
        end
    end

    // byte hand-off: data held, toggle announces it
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            byte_q <= '0;
            tgl_q  <= 1'b0;
        end else if (bitCnt_q == bpp_pkg::BIT_LAST) begin
            byte_q <= {shift_q, si};
            tgl_q  <= ~tgl_q;
        end
    end

    // survives chip select so the far side can see a ragged frame end
    always_ff @(posedge sck or negedge nrst) begin
        if (!nrst) begin
            partial_q <= 1'b0;
        end else begin
            partial_q <= (bitCnt_q != bpp_pkg::BIT_LAST);
        end
    end

    assign lnk.byteData = byte_q;
    assign lnk.byteTgl  = tgl_q;
    assign lnk.partial  = partial_q;
endmodule
`default_nettype wire

// [bpp_host_model.sv]
/*
 * Host-side model of the serial link: drives chip select, link clock, data.
 * Assumes the bench calls sendFrame only while the sequencer is idle.
 */
`timescale 1ns/1ns
`default_nettype none
module bpp_host_model (
    // serial pins
    output var logic sck,
    output var logic csN,
    output var logic si
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si  = 1'b0;
    end

    // mode 0, msb first; link clock only runs inside a frame
    task automatic sendFrame(input logic [7:0] b[$], input int tail);
        int k;
        csN = 1'b0;
        #37;
        foreach (b[i]) begin
            for (k = 7; k >= 0; k--) begin
                si = b[i][k];
                #62 sck = 1'b1;
                #63 sck = 1'b0;
            end
        end
        // loose bits past the last whole byte, only when asked for
        for (k = 0; k < tail; k++) begin
            si = ~si;
            #62 sck = 1'b1;
            #63 sck = 1'b0;
        end
        #41 csN = 1'b1;
        si = ~si;
    endtask
endmodule
`default_nettype wire

// [bpp_seq_top_tb_top.sv]
/*
 * Self-checking bench for the sequencer: host model on the link, a
 * behavioural array on the array port, expected requests in a queue.
 * Assumes the array port answers each request with one done pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module bpp_seq_top_tb_top;
    typedef struct {int cmd; int page; int col; int wd;} bpp_exp_t;

    logic               mclk = 1'b0;
    logic               nrst = 1'b0;
    logic               binaryMode = 1'b0;
    logic [7:0]         arrayRdata = 8'h00;
    logic               arrayDone = 1'b0;
    logic               arrayFail = 1'b0;
    wire                sck;
    wire                csN;
    wire                si;
    logic               deviceReady;
    logic               eraseProgramErrorFlag;
    logic               arrayReq;
    bpp_pkg::bpp_cmd_t  arrayCmd;
    logic [11:0]        arrayPage;
    logic [8:0]         arrayCol;
    logic [7:0]         arrayWdata;
    bpp_exp_t           expQ[$];
    bpp_exp_t           e;
    int                 errCount = 0;
    int                 testsRun = 0;
    int                 pend = 0;
    int                 reqNum = 0;
    int                 failIdx = -1;
    int                 curPage = 0;
    int                 curCol = 0;
    bit                 failNow = 1'b0;

    always #10 mclk = ~mclk;

    bpp_seq_top #(.EP_LIMIT_NS(2_000_000), .P_LIMIT_NS(2_000_000)) u_bpp_seq_top (
        .mclk(mclk), .nrst(nrst), .sck(sck), .csN(csN), .si(si),
        .binaryMode(binaryMode), .deviceReady(deviceReady),
        .eraseProgramErrorFlag(eraseProgramErrorFlag), .arrayReq(arrayReq),
        .arrayCmd(arrayCmd), .arrayPage(arrayPage), .arrayCol(arrayCol),
        .arrayWdata(arrayWdata), .arrayRdata(arrayRdata), .arrayDone(arrayDone),
        .arrayFail(arrayFail)
    );

    bpp_host_model u_bpp_host_model (.sck(sck), .csN(csN), .si(si));

    function automatic logic [7:0] rdPat(input int pg, input int c);
        return pg[7:0] ^ c[7:0] ^ 8'h5A;
    endfunction

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic reportAndStop();
        if (errCount == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // every array request is compared with the model's next expectation
    always @(posedge mclk) begin
        if (arrayReq === 1'b1) begin
            if (expQ.size() == 0) begin
                check("extra_req", 32'h0, 32'h1);
            end else begin
                e = expQ.pop_front();
                check("cmd", e.cmd, 32'(arrayCmd));
                check("page", e.page, 32'(arrayPage));
                if (e.col >= 0) check("col", e.col, 32'(arrayCol));
                if (e.wd >= 0) check("wdata", e.wd, 32'(arrayWdata));
                check("busy", 32'h0, 32'(deviceReady));
            end
            failNow = (reqNum == failIdx);
            reqNum++;
            curPage = int'(arrayPage);
            curCol = int'(arrayCol);
            pend = 1 + $urandom_range(3, 0);
        end
    end

    // array answers after a random delay; read data scrambles when not valid
    always @(posedge mclk) begin
        #1;
        arrayDone = 1'b0;
        arrayFail = 1'b0;
        arrayRdata = ~arrayRdata;
        if (pend > 0) begin
            pend--;
            if (pend == 0) begin
                arrayDone = 1'b1;
                arrayFail = failNow;
                arrayRdata = rdPat(curPage, curCol);
            end
        end
    end

    task automatic waitReady(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && deviceReady !== lvl; i++) @(posedge mclk);
        if (deviceReady !== lvl) begin
            check("ready_wait", 32'(lvl), 32'(deviceReady));
            reportAndStop();
        end
    endtask

    task automatic runOp(input logic [7:0] op, input logic bin, input int col, input int n,
                         input int tail, input bit fail);
        logic [7:0]  q[$];
        logic [7:0]  bufv[int];
        int          size;
        int          pg;
        int          i;
        int          pos;
        logic [23:0] a;
        size = bin ? 256 : 264;
        pg = $urandom_range(4095, 0);
        a = bin ? 24'(pg * 256 + col) : 24'(pg * 512 + col);
        q = '{op, a[23:16], a[15:8], a[7:0]};
        for (i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            bufv[(col + i) % size] = q[q.size() - 1];
        end
        if (op == 8'h82 || op == 8'h85) begin
            expQ.push_back(bpp_exp_t'{1, pg, -1, -1});
            for (pos = 0; pos < size; pos++)
                expQ.push_back(bpp_exp_t'{2, pg, pos, bufv.exists(pos) ? bufv[pos] : -1});
        end else if (tail == 0 && op == 8'h02) begin
            for (pos = 0; pos < size; pos++)
                if (bufv.exists(pos)) expQ.push_back(bpp_exp_t'{2, pg, pos, bufv[pos]});
        end else if (tail == 0 && (op == 8'h58 || op == 8'h59)) begin
            for (pos = 0; pos < size; pos++)
                if (!bufv.exists(pos)) expQ.push_back(bpp_exp_t'{0, pg, pos, -1});
            expQ.push_back(bpp_exp_t'{1, pg, -1, -1});
            for (pos = 0; pos < size; pos++)
                expQ.push_back(bpp_exp_t'{2, pg, pos,
                               bufv.exists(pos) ? bufv[pos] : rdPat(pg, pos)});
        end
        reqNum = 0;
        failIdx = fail ? expQ.size() - 1 : -1;
        @(posedge mclk);
        #1 binaryMode = bin;
        u_bpp_host_model.sendFrame(q, tail);
        if (expQ.size() > 0) begin
            waitReady(1'b0, 20);
            waitReady(1'b1, 40000);
            check("err_flag", 32'(fail), 32'(eraseProgramErrorFlag));
        end else begin
            repeat (12) @(posedge mclk);
            check("idle_ready", 32'h1, 32'(deviceReady));
        end
        check("left", 32'h0, 32'(expQ.size()));
        expQ.delete();
        repeat (10) @(posedge mclk);
    endtask

    initial begin
        void'($urandom(32'he0f6_7ca3));
        repeat (8) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge mclk);
        runOp(8'h82, 1'b0, 262, 3, 0, 1'b0);
        runOp(8'h85, 1'b1, 250, 10, 0, 1'b1);
        runOp(8'h02, 1'b0, 5, 2, 0, 1'b0);
        runOp(8'h02, 1'b1, 254, 4, 0, 1'b0);
        runOp(8'h02, 1'b0, 0, 264, 0, 1'b0);
        runOp(8'h58, 1'b0, 260, 6, 0, 1'b0);
        runOp(8'h59, 1'b1, 3, 0, 0, 1'b0);
        runOp(8'h58, 1'b1, 2, 3, 0, 1'b1);
        runOp(8'h02, 1'b0, 1, 3, 5, 1'b0);
        runOp(8'h59, 1'b0, 7, 2, 3, 1'b0);
        runOp(8'h82, 1'b0, 0, 2, 4, 1'b0);
        runOp(8'h1F, 1'b0, 0, 2, 0, 1'b0);
        reportAndStop();
    end
endmodule
`default_nettype wire
